// ---- rtl/gpfs_top.sv ----
// five-port gpio block with per-pin function select, pulls, masking and interrupts
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "gpfs_map.svh"

module gpfs_top #(
  parameter int NPORT = `GPFS_NPORT,
  parameter int NBIT = `GPFS_NBIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire gpfs_pkg::gpfs_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire gpfs_pkg::gpfs_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT*NBIT-1:0] pin_in,
  output logic [NPORT*NBIT-1:0] pin_out,
  output logic [NPORT*NBIT-1:0] pin_oe,
  output logic [NPORT*NBIT-1:0] pin_pull_up,
  output logic [NPORT*NBIT-1:0] pin_pull_down,
  output logic [NPORT*NBIT-1:0] pin_analog_en,
  input wire logic [NPORT*NBIT*`GPFS_NCODE-1:0] alt_out,
  input wire logic [NPORT*NBIT*`GPFS_NCODE-1:0] alt_oe,
  output logic [NPORT*NBIT-1:0] alt_in,
  output logic [NPORT-1:0] port_irq
);
  import gpfs_pkg::*;

  localparam int NPIN = NPORT * NBIT;
  localparam int CW = `GPFS_CODE_W;

  // whole state: one row per port for the control registers
  typedef struct packed {
    logic [NPORT-1:0][NBIT-1:0] dat;
    logic [NPORT-1:0][NBIT-1:0] dir;
    logic [NPORT-1:0][NBIT-1:0] isen;
    logic [NPORT-1:0][NBIT-1:0] ibe;
    logic [NPORT-1:0][NBIT-1:0] iev;
    logic [NPORT-1:0][NBIT-1:0] im;
    logic [NPORT-1:0][NBIT-1:0] ris;
    logic [NPORT-1:0][NBIT-1:0] afs;
    logic [NPORT-1:0][NBIT-1:0] pur;
    logic [NPORT-1:0][NBIT-1:0] pdr;
    logic [NPORT-1:0][NBIT-1:0] digital_in_enable_bit;
    logic [NPORT-1:0][NBIT*CW-1:0] pctl;
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pu;
    logic [NPIN-1:0] pd;
    logic [NPIN-1:0] ana;
    logic [NPIN-1:0] ain;
    logic [NPORT-1:0] irq;
  } gpfs_state_s;

  gpfs_state_s st_reg;
  gpfs_state_s st_next;

  logic wr_fire;
  gpfs_addr_t wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [31:0] rd_data;
  logic rd_err;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_prev;

  // bonded pins per port; unbonded bits of the byte registers read zero (pctl reads back unmasked) and never drive
  function automatic gpfs_byte_t present(input int p);
    case (p)
      0: present = `GPFS_PRESENT_A;
      4: present = `GPFS_PRESENT_E;
      default: present = `GPFS_PRESENT_FULL;
    endcase
  endfunction

  // alt select and digital enable share one reset pattern
  function automatic gpfs_byte_t sel_rst(input int p);
    case (p)
      0: sel_rst = `GPFS_A_SEL_RST;
      2: sel_rst = `GPFS_C_SEL_RST;
      default: sel_rst = '0;
    endcase
  endfunction

  function automatic gpfs_byte_t pur_rst(input int p);
    case (p)
      0: pur_rst = `GPFS_A_PULL_UP_RST;
      2: pur_rst = `GPFS_C_PULL_UP_RST;
      default: pur_rst = '0;
    endcase
  endfunction

  function automatic logic [NBIT*CW-1:0] pctl_rst(input int p);
    case (p)
      0: pctl_rst = `GPFS_A_PCTL_RST;
      2: pctl_rst = `GPFS_C_PCTL_RST;
      default: pctl_rst = '0;
    endcase
  endfunction

  // pins come from outside the clock domain
  gpfs_sync #(
    .W(NPIN)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_in(pin_in),
    .q(pin_sync),
    .q_prev(pin_prev)
  );

  gpfs_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_fire(wr_fire),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // unmapped addresses answer with slverr
  assign wr_err = (gpfs_decode(wr_addr) == R_NONE) && !gpfs_is_pctl(wr_addr);
  assign rd_err = (gpfs_decode(s_axi_araddr) == R_NONE) && !gpfs_is_pctl(s_axi_araddr);

  // read mux, sampled by the slave on the address handshake
  always_comb
  begin
    int p;
    gpfs_byte_t v;
    p = int'(s_axi_araddr[`GPFS_PORT_HI:`GPFS_PORT_LO]);
    v = '0;
    rd_data = '0;
    if (p < NPORT)
    begin
      case (gpfs_decode(s_axi_araddr))
        R_DATA: v = st_reg.dat[p] & s_axi_araddr[9:2];
        R_DIR: v = st_reg.dir[p];
        R_IS: v = st_reg.isen[p];
        R_IBE: v = st_reg.ibe[p];
        R_IEV: v = st_reg.iev[p];
        R_IM: v = st_reg.im[p];
        R_RIS: v = st_reg.ris[p];
        R_MIS: v = st_reg.ris[p] & st_reg.im[p];
        R_AFS: v = st_reg.afs[p];
        R_PUR: v = st_reg.pur[p];
        R_PDR: v = st_reg.pdr[p];
        R_DEN: v = st_reg.digital_in_enable_bit[p];
        default: v = '0;
      endcase
      rd_data = {24'h000000, v & present(p)};
      if (gpfs_is_pctl(s_axi_araddr))
        rd_data = st_reg.pctl[p];
    end
  end

  // register writes, input capture, interrupt detection and pin muxing
  always_comb
  begin
    int wp;
    int i;
    int c;
    gpfs_reg_e wsel;
    logic wb;
    gpfs_byte_t clr;
    gpfs_byte_t s;
    gpfs_byte_t sp;
    gpfs_byte_t ev;
    gpfs_byte_t pr;
    st_next = st_reg;
    wp = int'(wr_addr[`GPFS_PORT_HI:`GPFS_PORT_LO]);
    wsel = gpfs_decode(wr_addr);
    wb = wr_fire && wr_strb[0];
    clr = '0;
    i = 0;
    c = 0;
    s = '0;
    sp = '0;
    ev = '0;
    pr = '0;
    if (wr_fire && wp < NPORT)
    begin
      // written per byte lane under wr_strb; each lane holds the fields of two pins
      if (gpfs_is_pctl(wr_addr))
      begin
        for (int k = 0; k < 4; k++)
          if (wr_strb[k])
            st_next.pctl[wp][k*8 +: 8] = wr_data[k*8 +: 8];
      end
      if (wb)
      begin
        case (wsel)
          R_DATA: st_next.dat[wp] = (st_reg.dat[wp] & ~wr_addr[9:2])
            | (wr_data[7:0] & wr_addr[9:2]);
          R_DIR: st_next.dir[wp] = wr_data[7:0];
          R_IS: st_next.isen[wp] = wr_data[7:0];
          R_IBE: st_next.ibe[wp] = wr_data[7:0];
          R_IEV: st_next.iev[wp] = wr_data[7:0];
          R_IM: st_next.im[wp] = wr_data[7:0];
          R_ICR: clr = wr_data[7:0];
          R_AFS: st_next.afs[wp] = wr_data[7:0];
          R_PUR: st_next.pur[wp] = wr_data[7:0];
          R_PDR: st_next.pdr[wp] = wr_data[7:0];
          R_DEN: st_next.digital_in_enable_bit[wp] = wr_data[7:0];
          default: ;
        endcase
      end
    end
    for (int p = 0; p < NPORT; p++)
    begin
      s = pin_sync[p*NBIT +: NBIT] & st_reg.digital_in_enable_bit[p];
      sp = pin_prev[p*NBIT +: NBIT] & st_reg.digital_in_enable_bit[p];
      // inputs follow the pin, outputs keep the written value
      st_next.dat[p] = (st_next.dat[p] & st_reg.dir[p]) | (s & ~st_reg.dir[p]);
      ev = (st_reg.ibe[p] & (s ^ sp)) | (~st_reg.ibe[p] & st_reg.iev[p] & s & ~sp)
        | (~st_reg.ibe[p] & ~st_reg.iev[p] & ~s & sp);
      // edge flags are sticky; a new edge beats a same-cycle clear
      for (int b = 0; b < NBIT; b++)
      begin
        if (st_reg.isen[p][b])
          st_next.ris[p][b] = st_reg.digital_in_enable_bit[p][b] && (s[b] == st_reg.iev[p][b]);
        else
          st_next.ris[p][b] = (st_reg.ris[p][b] && !(p == wp && clr[b])) || ev[b];
      end
      st_next.ris[p] = st_next.ris[p] & present(p);
      st_next.irq[p] = |(st_reg.ris[p] & st_reg.im[p]);
    end
    // reset lands before the pin mux, so drive and pulls show defaults at once
    if (!aresetn)
    begin
      st_next = '0;
      for (int p = 0; p < NPORT; p++)
      begin
        st_next.afs[p] = sel_rst(p);
        st_next.digital_in_enable_bit[p] = sel_rst(p);
        st_next.pur[p] = pur_rst(p);
        st_next.pctl[p] = pctl_rst(p);
      end
    end
    for (int p = 0; p < NPORT; p++)
    begin
      pr = present(p);
      // pin drive taken from next values so a write shows on the next edge
      for (int b = 0; b < NBIT; b++)
      begin
        i = p * NBIT + b;
        c = int'(st_next.pctl[p][b*CW +: CW]);
        if (st_next.afs[p][b] && st_next.digital_in_enable_bit[p][b])
        begin
          st_next.out[i] = alt_out[i*`GPFS_NCODE + c];
          st_next.oe[i] = alt_oe[i*`GPFS_NCODE + c];
        end
        else
        begin
          st_next.out[i] = st_next.dat[p][b];
          st_next.oe[i] = st_next.dir[p][b] && !st_next.afs[p][b];
        end
        st_next.oe[i] = st_next.oe[i] && pr[b];
        st_next.pu[i] = st_next.pur[p][b];
        st_next.pd[i] = st_next.pdr[p][b];
        st_next.ana[i] = !st_next.digital_in_enable_bit[p][b] && pr[b];
        st_next.ain[i] = pin_sync[i] && st_next.afs[p][b] && st_next.digital_in_enable_bit[p][b];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    st_reg <= st_next;
  end

  assign pin_out = st_reg.out;
  assign pin_oe = st_reg.oe;
  assign pin_pull_up = st_reg.pu;
  assign pin_pull_down = st_reg.pd;
  assign pin_analog_en = st_reg.ana;
  assign alt_in = st_reg.ain;
  assign port_irq = st_reg.irq;

endmodule // gpfs_top

`default_nettype wire

// ---- rtl/gpfs_map.svh ----
// register offsets, field layout, reset values and sizes of the pin function select block
`ifndef GPFS_MAP_SVH
`define GPFS_MAP_SVH

// geometry: five ports of eight bits, 4-bit function code per pin
`define GPFS_NPORT 5
`define GPFS_NBIT 8
`define GPFS_CODE_W 4
`define GPFS_NCODE 16
`define GPFS_ADDR_W 15

// port select sits in address bits 14:12
`define GPFS_PORT_HI 14
`define GPFS_PORT_LO 12

// register offsets inside one port window
`define GPFS_OFS_DATA 12'h000
`define GPFS_OFS_DIR 12'h400
`define GPFS_OFS_IS 12'h404
`define GPFS_OFS_IBE 12'h408
`define GPFS_OFS_IEV 12'h40c
`define GPFS_OFS_IM 12'h410
`define GPFS_OFS_RIS 12'h414
`define GPFS_OFS_MIS 12'h418
`define GPFS_OFS_ICR 12'h41c
`define GPFS_OFS_AFS 12'h420
`define GPFS_OFS_PUR 12'h424
`define GPFS_OFS_PDR 12'h428
`define GPFS_OFS_DEN 12'h42c
`define GPFS_OFS_PCTL 12'h430

// bonded pins per port (a and e carry six pins): 36 in all
`define GPFS_PRESENT_A 8'h3f
`define GPFS_PRESENT_E 8'h3f
`define GPFS_PRESENT_FULL 8'hff

// reset values of the claimed pins
`define GPFS_A_SEL_RST 8'h3f
`define GPFS_A_PULL_UP_RST 8'h00
`define GPFS_A_PCTL_RST 32'h00111111
`define GPFS_C_SEL_RST 8'h0f
`define GPFS_C_PULL_UP_RST 8'h0f
`define GPFS_C_PCTL_RST 32'h00003333

// bus responses
`define GPFS_RESP_OKAY 2'b00
`define GPFS_RESP_SLVERR 2'b10

`endif

// ---- rtl/gpfs_pkg.sv ----
// types and address decoding shared by the pin function select block
`include "gpfs_map.svh"

package gpfs_pkg;

  typedef logic [`GPFS_NBIT-1:0] gpfs_byte_t;
  typedef logic [`GPFS_ADDR_W-1:0] gpfs_addr_t;

  // one-hot register select
  typedef enum logic [13:0] {
    R_NONE = 14'h0001,
    R_DATA = 14'h0002,
    R_DIR = 14'h0004,
    R_IS = 14'h0008,
    R_IBE = 14'h0010,
    R_IEV = 14'h0020,
    R_IM = 14'h0040,
    R_RIS = 14'h0080,
    R_MIS = 14'h0100,
    R_ICR = 14'h0200,
    R_AFS = 14'h0400,
    R_PUR = 14'h0800,
    R_PDR = 14'h1000,
    R_DEN = 14'h2000
  } gpfs_reg_e;

  // pctl has its own flag since it is the one 32-bit register
  function automatic logic gpfs_is_pctl(input gpfs_addr_t a);
    gpfs_is_pctl = (a[`GPFS_PORT_HI:`GPFS_PORT_LO] < 3'(`GPFS_NPORT))
      && (a[11:2] == `GPFS_OFS_PCTL >> 2);
  endfunction

  // map a byte address to a register; unmapped gives R_NONE
  function automatic gpfs_reg_e gpfs_decode(input gpfs_addr_t a);
    gpfs_decode = R_NONE;
    if (a[`GPFS_PORT_HI:`GPFS_PORT_LO] < 3'(`GPFS_NPORT))
    begin
      if (a[11:0] < `GPFS_OFS_DIR)
        gpfs_decode = R_DATA;
      else
      begin
        case ({a[11:2], 2'b00})
          `GPFS_OFS_DIR: gpfs_decode = R_DIR;
          `GPFS_OFS_IS: gpfs_decode = R_IS;
          `GPFS_OFS_IBE: gpfs_decode = R_IBE;
          `GPFS_OFS_IEV: gpfs_decode = R_IEV;
          `GPFS_OFS_IM: gpfs_decode = R_IM;
          `GPFS_OFS_RIS: gpfs_decode = R_RIS;
          `GPFS_OFS_MIS: gpfs_decode = R_MIS;
          `GPFS_OFS_ICR: gpfs_decode = R_ICR;
          `GPFS_OFS_AFS: gpfs_decode = R_AFS;
          `GPFS_OFS_PUR: gpfs_decode = R_PUR;
          `GPFS_OFS_PDR: gpfs_decode = R_PDR;
          `GPFS_OFS_DEN: gpfs_decode = R_DEN;
          default: gpfs_decode = R_NONE;
        endcase
      end
    end
  endfunction

endpackage

// ---- rtl/gpfs_sync.sv ----
// two-flop input synchroniser with one extra stage for edge detection
`timescale 1ns/1ps
`default_nettype none

module gpfs_sync #(
  parameter int W = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q,
  output logic [W-1:0] q_prev
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } gpfs_sync_s;

  gpfs_sync_s st_reg;
  gpfs_sync_s st_next;

  // meta is read only by the second stage
  always_comb
  begin
    st_next.meta = d_in;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
    if (!aresetn)
      st_next = '0;
  end

  always_ff @(posedge aclk)
  begin
    st_reg <= st_next;
  end

  assign q = st_reg.sync;
  assign q_prev = st_reg.prev;

endmodule // gpfs_sync

`default_nettype wire

// ---- rtl/gpfs_axil.sv ----
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
`include "gpfs_map.svh"

module gpfs_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire gpfs_pkg::gpfs_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_fire,
  output gpfs_pkg::gpfs_addr_t wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  import gpfs_pkg::*;

  typedef struct packed {
    logic aw_have;
    gpfs_addr_t awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpfs_axil_s;

  gpfs_axil_s st_reg;
  gpfs_axil_s st_next;

  // commit once both halves of the write are held
  assign wr_fire = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
  assign wr_addr = st_reg.awaddr;
  assign wr_data = st_reg.wdata;
  assign wr_strb = st_reg.wstrb;

  // channel handshakes; ready flags registered so ports come from flops
  always_comb
  begin
    st_next = st_reg;
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.w_have = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_err ? `GPFS_RESP_SLVERR : `GPFS_RESP_OKAY;
    end
    else if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    // a new write may wait while bvalid stands, so pins can toggle every 2 cycles
    st_next.awready = !st_next.aw_have;
    st_next.wready = !st_next.w_have;
    // read data is latched on the address edge itself
    if (s_axi_arvalid && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_data;
      st_next.rresp = rd_err ? `GPFS_RESP_SLVERR : `GPFS_RESP_OKAY;
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    st_next.arready = !st_next.rvalid;
    if (!aresetn)
      st_next = '0;
  end

  always_ff @(posedge aclk)
  begin
    st_reg <= st_next;
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

endmodule // gpfs_axil

`default_nettype wire

// ---- tb/gpfs_top_properties.sv ----
// concurrent checks on the ports of the pin function select block
`timescale 1ns/1ps
`default_nettype none
`include "gpfs_map.svh"

module gpfs_top_properties #(
  parameter int NPORT = 5,
  parameter int NBIT = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT*NBIT-1:0] pin_oe,
  input wire logic [NPORT*NBIT-1:0] pin_pull_up,
  input wire logic [NPORT*NBIT-1:0] pin_pull_down,
  input wire logic [NPORT*NBIT-1:0] pin_analog_en,
  input wire logic [NPORT*NBIT*`GPFS_NCODE-1:0] alt_oe,
  input wire logic [NPORT*NBIT-1:0] alt_in
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // high in the first cycle after a reset, when outputs must show defaults
  logic rst_seen_reg;
  always_ff @(posedge aclk)
    rst_seen_reg <= !aresetn;

  // write address and data taken together, then response waits on bready
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_held;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  pull_rst_a: assert property (rst_seen_reg |-> pin_pull_up == 40'h00000f0000 && pin_pull_down == '0)
    else $error("pull defaults wrong after reset");
  analog_rst_a: assert property (rst_seen_reg |-> pin_analog_en == 40'h3ffff0ff00)
    else $error("analog defaults wrong after reset");
  drive_rst_a: assert property (rst_seen_reg |-> pin_oe[39:20] == '0 && pin_oe[15:6] == '0
    && pin_oe[16] == alt_oe[259] && pin_oe[0] == alt_oe[1])
    else $error("drive enables wrong after reset");
  unbonded_quiet_a: assert property (pin_oe[7:6] == 2'b00 && pin_oe[39:38] == 2'b00)
    else $error("unbonded pin driven");
  analog_quiet_a: assert property ((pin_analog_en & $past(pin_analog_en) & alt_in) == '0)
    else $error("peripheral input seen on analog pin");
  wr_resp_a: assert property (wr_taken ##0 (s_axi_bready || !s_axi_bvalid)
    |=> ##1 s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (resp_held |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // gpfs_top_properties

bind gpfs_top gpfs_top_properties #(.NPORT(NPORT), .NBIT(NBIT)) chk_u (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
  .pin_pull_down(pin_pull_down), .pin_analog_en(pin_analog_en), .alt_oe(alt_oe),
  .alt_in(alt_in));
`default_nettype wire

// ---- tb/gpfs_pin_model.sv ----
// pads and on-chip peripherals around the pin function select block
`timescale 1ns/1ps
`default_nettype none

module gpfs_pin_model #(
  parameter int NPIN = 40,
  parameter int NALT = 640
) (
  input wire logic aclk,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pin_pull_up,
  input wire logic [NPIN-1:0] pin_pull_down,
  input wire logic [NPIN-1:0] ext_level,
  input wire logic [NPIN-1:0] ext_en,
  output logic [NPIN-1:0] pin_in,
  output logic [NALT-1:0] alt_out,
  output logic [NALT-1:0] alt_oe
);
  // floating pads wander each cycle, so a stale level never reads as valid
  logic [NPIN-1:0] float_reg = '0;
  always_ff @(posedge aclk)
    float_reg <= ~float_reg;

  // pad level: block drive, then outside driver, then pulls, else floating
  always_comb
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_level)
      | (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & float_reg)));

  // peripherals with codes 1 to 15 drive when selected, code 0 never; level follows code parity
  always_comb
    for (int k = 0; k < NALT; k++)
    begin
      alt_out[k] = 1'(k % 2);
      alt_oe[k] = (k % 16) != 0;
    end
endmodule // gpfs_pin_model
`default_nettype wire

// ---- tb/tb_gpio_pin_function_select.sv ----
// register-level tests of the pin function select block
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_pin_function_select;
  import gpfs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  gpfs_addr_t s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [39:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_analog_en, alt_in;
  logic [39:0] ext_level, ext_en;
  logic [639:0] alt_out, alt_oe;
  logic [4:0] port_irq;
  logic [6:0] modes [7];
  int bad_count = 0;
  int num_checks = 0;

  always #2.5 aclk = ~aclk;

  gpfs_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .pin_analog_en(pin_analog_en),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .port_irq(port_irq));

  gpfs_pin_model pm_u (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .ext_level(ext_level),
    .ext_en(ext_en), .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bready rises only once bvalid is seen, so the response is held a cycle
  task automatic wr(input logic [14:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      print_verdict();
    end
    check_reg({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [14:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      print_verdict();
    end
    check_reg(s_axi_rdata, exp);
    check_reg({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // claimed pins come up on their peripherals, all other bonded pins with digital input off and analog enabled
  task automatic chk_def;
    rd(15'h0420, 32'h3f);
    rd(15'h042c, 32'h3f);
    rd(15'h0430, 32'h00111111);
    rd(15'h2420, 32'h0f);
    rd(15'h2424, 32'h0f);
    rd(15'h2430, 32'h00003333);
    rd(15'h1420, 32'h0);
    rd(15'h3430, 32'h0);
    rd(15'h2428, 32'h0);
    check_pin(pin_oe, 40'h00000f003f);
    check_pin(pin_out, 40'h00000f003f);
    check_pin(pin_pull_up, 40'h00000f0000);
    check_pin(pin_analog_en, 40'h3ffff0ff00);
  endtask

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    ext_level = 40'h005a000000;
    ext_en = 40'h00ff000000;
    // rows: sense, both, event, start, end, mask, expected irq
    modes = '{7'b0010111, 7'b0001011, 7'b0100111, 7'b1010111, 7'b1001011, 7'b0010100, 7'b0011010};
    do_reset();
    chk_def();
    rd(15'h5420, 32'h0, 2'b10);
    wr(15'h5420, 32'h1, 2'b10);
    $display("test defaults done");
    wr(15'h0420, 32'h0);
    wr(15'h2424, 32'h0);
    check_pin(pin_pull_up, 40'h0);
    do_reset();
    chk_def();
    $display("test second reset done");
    wr(15'h142c, 32'hff);
    wr(15'h1400, 32'hff);
    wr(15'h13fc, 32'haa);
    check_pin({32'h0, pin_out[15:8]}, 40'haa);
    check_pin({32'h0, pin_oe[15:8]}, 40'hff);
    wr(15'h103c, 32'h55);
    check_pin({32'h0, pin_out[15:8]}, 40'ha5);
    rd(15'h13c0, 32'ha0);
    for (int k = 0; k < 4; k++)
    begin
      wr(15'h1004, 32'(k % 2));
      check_pin({39'h0, pin_out[8]}, 40'(k % 2));
    end
    $display("test output and masking done");
    rd(15'h33fc, 32'h0);
    check_pin({32'h0, pin_analog_en[31:24]}, 40'hff);
    wr(15'h342c, 32'hff);
    cyc(4);
    rd(15'h33fc, 32'h5a);
    check_pin({32'h0, pin_analog_en[31:24]}, 40'h0);
    $display("test input and analog done");
    wr(15'h4430, 32'h00765432);
    wr(15'h4420, 32'h3f);
    cyc(2);
    check_pin({32'h0, pin_oe[39:32]}, 40'h0);
    wr(15'h442c, 32'h3f);
    cyc(2);
    check_pin({32'h0, pin_oe[39:32]}, 40'h3f);
    check_pin({32'h0, pin_out[39:32]}, 40'h2a);
    cyc(4);
    check_pin({32'h0, alt_in[39:32]}, 40'h2a);
    $display("test alternate function done");
    // mask first, so the setup itself cannot raise a stray interrupt
    for (int k = 0; k < 7; k++)
    begin
      wr(15'h3410, 32'h0);
      ext_level[24] <= modes[k][3];
      wr(15'h3404, {31'h0, modes[k][6]});
      wr(15'h3408, {31'h0, modes[k][5]});
      wr(15'h340c, {31'h0, modes[k][4]});
      wr(15'h341c, 32'h1);
      wr(15'h3410, {31'h0, modes[k][1]});
      ext_level[24] <= modes[k][2];
      cyc(6);
      check_pin({39'h0, port_irq[3]}, {39'h0, modes[k][0]});
      rd(15'h3418, {31'h0, modes[k][0]});
      wr(15'h341c, 32'h1);
      cyc(2);
      check_pin({39'h0, port_irq[3]}, {39'h0, modes[k][0] & modes[k][6]});
    end
    $display("test interrupt modes done");
    print_verdict();
  end
endmodule // tb_gpio_pin_function_select
`default_nettype wire
